// [dv/sps_periph_model.sv]
// Tape units, typewriter and punch: each answers an arm with a done pulse.
// Assumes arm and start strobes are one-cycle pulses on hclk.
`timescale 1ns/1ns
module sps_periph_model #(parameter int DLY = 40) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Starts from the sequencer
  input wire logic [3:0] arm_tape_busy,
  input wire logic print_start,
  input wire logic punch_start,
  // Completions
  output logic [3:0] tape_done,
  output logic typewriter_done,
  output logic punch_done
);
  int cnt [6];
  logic [5:0] arm;
  logic [5:0] done;
  assign arm = {punch_start, print_start, arm_tape_busy};
  assign {punch_done, typewriter_done, tape_done} = done;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 6'h00;
      foreach (cnt[i]) cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        done[i] <= (cnt[i] == 1);
        if (arm[i]) cnt[i] <= DLY;
        else if (cnt[i] > 0) cnt[i] <= cnt[i] - 1;
      end
    end
  end
endmodule // sps_periph_model

// [dv/sps_properties.sv]
// Port assertions for the step pulse sequencer.
// Assumes one hclk domain and binding onto sps_sequencer.
`timescale 1ns/1ns
module sps_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stepping
  input wire logic step_advance_req,
  input wire logic [7:0] step_pulse,
  input wire logic ext_wait,
  // Lockouts
  input wire logic [3:0] tape_permit,
  input wire logic typewriter_permit,
  input wire logic [3:0] arm_tape_busy,
  input wire logic [3:0] tape_done,
  input wire logic typewriter_done,
  input wire logic tape_xfer_wait_req,
  input wire logic print_start,
  input wire logic punch_start
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_xfer_hold;
    tape_xfer_wait_req ##[0:1] ext_wait;
  endsequence
  a_pulse_onehot: assert property ($onehot0(step_pulse)) else $error("step pulse not one-hot");
  a_pulse_cause: assert property (step_pulse != 8'h00 |-> $past(step_advance_req) && !$past(ext_wait))
    else $error("pulse without accepted advance");
  a_wait_blocks: assert property (ext_wait |=> step_pulse == 8'h00) else $error("pulse while waiting");
  a_tape_arm_p5: assert property (arm_tape_busy != 4'h0 |-> step_pulse[5]) else $error("tape armed off pulse 5");
  a_tape_permit_drop: assert property (arm_tape_busy != 4'h0 |=> (tape_permit & $past(arm_tape_busy)) == 4'h0)
    else $error("permit kept after arming");
  a_xfer_wait_p5: assert property (tape_xfer_wait_req |-> step_pulse[5] ##0 s_xfer_hold)
    else $error("transfer wait misplaced");
  a_print_p2: assert property (print_start || punch_start |-> step_pulse[2]) else $error("print off pulse 2");
  a_tw_permit_drop: assert property (print_start |=> !typewriter_permit) else $error("typewriter permit kept");
  // A fresh arm in the done cycle or the one after keeps the permit low, so both are excluded.
  a_done_permit: assert property (tape_done[0] ##1 !arm_tape_busy[0] ##1 !arm_tape_busy[0] |-> tape_permit[0])
    else $error("tape permit not restored");
  a_tw_done_permit: assert property (typewriter_done ##1 !print_start ##1 !print_start |-> typewriter_permit)
    else $error("typewriter permit not restored");
endmodule // sps_properties

bind sps_sequencer sps_properties u_props (.hclk(hclk), .hresetn(hresetn), .step_advance_req(step_advance_req),
  .step_pulse(step_pulse), .ext_wait(ext_wait), .tape_permit(tape_permit), .typewriter_permit(typewriter_permit),
  .arm_tape_busy(arm_tape_busy), .tape_done(tape_done), .typewriter_done(typewriter_done),
  .tape_xfer_wait_req(tape_xfer_wait_req), .print_start(print_start), .punch_start(punch_start));

// [dv/step_pulse_sequencer_io_lockout_tb.sv]
// Self-checking bench for the step pulse sequencer.
// Assumes sps_sequencer, the peripheral model and the bound checker.
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module step_pulse_sequencer_io_lockout_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, step_advance_req = 0;
  logic repeat_active = 0, special_load = 0;
  logic [2:0] special_step = 3'h0, hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h5f32, r;
  logic [1:0] htrans = 0, tape_sel = 0;
  logic [5:0] opcode = 6'o11;
  logic [7:0] step_pulse, e_pulse, exp_q[$];
  logic [3:0] tape_permit, arm_tape_busy, tape_done;
  logic typewriter_permit, punch_permit, ext_wait, tape_xfer_wait_req, print_start, punch_start;
  logic typewriter_done, punch_done, hreadyout, hresp;
  wire hready = hreadyout;
  int n_mismatch = 0, num_checks = 0;
  // Code in the upper octal digits, last pulse before pulse 5 in the last one.
  int tab[] = '{'o110, 'o130, 'o150, 'o160, 'o440, 'o450, 'o460, 'o560, 'o121, 'o171, 'o311, 'o321, 'o331,
    'o341, 'o471, 'o761, 'o771, 'o142, 'o352, 'o362, 'o512, 'o542, 'o423, 'o523, 'o533, 'o553, 'o713, 'o723,
    'o733, 'o214, 'o234, 'o274, 'o374, 'o414, 'o434, 'o614, 'o634, 'o644, 'o654, 'o664, 'o674, 'o744};
  sps_sequencer u_dut (.*);
  sps_periph_model #(.DLY(40)) u_periph (.*);
  initial forever #20 hclk = ~hclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    if (!w) `CHK(hrdata, e)
  endtask
  // Notes the pulse, then advances until the monitor has seen it.
  task automatic step(input int n);
    exp_q.push_back(8'h01 << n);
    while (exp_q.size() != 0) begin
      @(posedge hclk) step_advance_req <= 1;
      @(posedge hclk) step_advance_req <= 0;
      repeat (2) @(posedge hclk);
    end
  endtask
  task automatic run(input logic [5:0] op, input logic [1:0] sel, input int np, input int w1);
    @(posedge hclk);
    opcode <= op;
    tape_sel <= sel;
    step(0);
    for (int i = 1; i <= np; i++) begin
      step(i);
      if (i == 1 && w1 >= 0) `CHK(ext_wait, w1[0])
    end
    step(5);
    if (op == 6'o64 || op == 6'o65) `CHK(ext_wait, 1'b1)
    step(6);
    step(7);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (step_pulse !== 8'h00) begin
      e_pulse = (exp_q.size() != 0) ? exp_q.pop_front() : 8'h00;
      `CHK(step_pulse, e_pulse)
    end
  end
  initial begin
    #(40 * 40000);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    `CHK({tape_permit, typewriter_permit, punch_permit, ext_wait}, 7'h7e)
    bus(0, 32'h4, 0, 32'h0);
    bus(0, 32'h10, 0, 32'h0);
    bus(1, 32'h0, 32'h5, 0);
    bus(0, 32'h0, 0, 32'h1);
    bus(0, 32'h8, 0, 32'h1);
    $display("register test done");
    foreach (tab[i]) begin
      r = xs();
      run(6'(tab[i] >> 3), r[1:0], tab[i] % 8, -1);
    end
    $display("pulse table test done");
    run(6'o66, 0, 4, -1);
    `CHK(tape_permit[0], 1'b0)
    run(6'o67, 0, 4, 1);
    run(6'o66, 1, 4, -1);
    run(6'o66, 3, 4, 0);
    run(6'o61, 0, 4, -1);
    run(6'o61, 0, 4, 1);
    run(6'o63, 1, 4, -1);
    run(6'o63, 1, 4, 1);
    $display("lockout test done");
    @(posedge hclk);
    opcode <= 6'o12;
    repeat_active <= 1;
    step(0);
    step(1);
    step(5);
    step(7);
    repeat_active <= 0;
    special_load <= 1;
    special_step <= 3'd6;
    @(posedge hclk);
    special_load <= 0;
    step(6);
    step(7);
    $display("special cycle test done");
    @(posedge hclk);
    opcode <= 6'o64;
    tape_sel <= 2;
    for (int i = 0; i <= 5; i++) step(i);
    bus(1, 32'h0, 32'h5, 0);
    repeat (3) @(posedge hclk);
    `CHK(ext_wait, 1'b0)
    step(6);
    step(7);
    $display("start clear test done");
    opcode <= 6'o57;
    step(0);
    bus(0, 32'h0, 0, 32'h0);
    $display("final stop test done");
    close_out();
  end
endmodule // step_pulse_sequencer_io_lockout_tb

// [verilog/sps_map.vh]
// Constants for the step pulse sequencer with peripheral lockouts.
// Assumes a 25 MHz hclk and a word-wide AHB-Lite register slave.
//
// Notes on behaviour
// - Tape move step5 arms busy, drops permit.
// - Tape step1 on busy unit sets wait.
// - Tape done clears that unit's busy flag.
// - Free unit restores permit, next advance request clears wait.
// - Read/write: test step1; wait and arm step5.
// - Read/write wait holds until done then pulse.
// - Four identical tape lockout circuits.
// - Print: test step1, arm typewriter on step2.
// - Typewriter busy on code 61 withholds permit.
// - Print done clears busy, permit, then wait.
// - Punch behaves as typewriter with own flag.
// - Four to eight steps, pulses only on advance.
// - Short codes give pulses 0,5,6,7.
// - Five-pulse codes give 0,1,5,6,7.
// - Six-pulse codes give 0,1,2,5,6,7.
// - Seven-pulse codes give 0,1,2,3,5,6,7.
// - Eight-pulse codes give all pulses.
// - Codes 57, 75 and repeat use special cycles.
// - Each pulse loads the next step number.
// - Gate open only if step held and needed.
// - Pulse 5 when no other gate open.
// - Start selection clears all wait flags.
`ifndef SPS_MAP_VH
`define SPS_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPS_CTRL_OFS 8'h00
`define SPS_STAT_OFS 8'h04
`define SPS_PULSE_OFS 8'h08

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPS_CTRL_START_BIT 0
`define SPS_CTRL_STOP_BIT 1
`define SPS_CTRL_CLEAR_BIT 2
`define SPS_CTRL_RESET 3'h2

// ----------------------------------------------------------------
// Operation codes (octal values as six-bit codes)
// ----------------------------------------------------------------
`define SPS_OP_READ 6'o64
`define SPS_OP_WRITE 6'o65
`define SPS_OP_ADV 6'o66
`define SPS_OP_BACK 6'o67
`define SPS_OP_PRINT 6'o61
`define SPS_OP_PUNCH 6'o63
`define SPS_OP_STOP 6'o57
`define SPS_OP_REPEAT 6'o75

`endif

// [verilog/sps_sequencer.v]
// Step pulse sequencer with tape, typewriter and punch lockouts.
// Assumes every input except the bus comes from hclk-domain logic.
`timescale 1ns/1ns
`include "sps_map.vh"

module sps_sequencer (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Operation decoder and command timing
  input wire [5:0] opcode,
  input wire [1:0] tape_sel,
  input wire repeat_active,
  input wire step_advance_req,
  input wire special_load,
  input wire [2:0] special_step,
  output reg [7:0] step_pulse,
  output reg [3:0] tape_permit,
  output reg typewriter_permit,
  output reg punch_permit,
  output reg ext_wait,
  // Peripherals
  input wire [3:0] tape_done,
  input wire typewriter_done,
  input wire punch_done,
  output reg [3:0] arm_tape_busy,
  output reg tape_xfer_wait_req,
  output reg print_start,
  output reg punch_start
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  reg ph_wr_ff;
  reg ph_rd_ff;
  reg [7:0] ph_addr_ff;
  reg run_ff;
  reg start_sel_ff;
  wire req = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff <= 1'b0;
      ph_rd_ff <= 1'b0;
      ph_addr_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr_ff <= req & hwrite;
      ph_rd_ff <= req & ~hwrite;
      ph_addr_ff <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Lockout flags and wait
  // ----------------------------------------------------------------
  reg [3:0] tape_busy_ff;
  reg tw_busy_ff;
  reg hp_busy_ff;
  reg [2:0] step_ff;
  reg ext_wait_ff;
  wire [3:0] unit_hot = 4'h1 << tape_sel;
  wire is_tape = (opcode >= `SPS_OP_READ) && (opcode <= `SPS_OP_BACK);
  wire is_rw = (opcode == `SPS_OP_READ) || (opcode == `SPS_OP_WRITE);
  wire is_tw = opcode == `SPS_OP_PRINT;
  wire is_hp = opcode == `SPS_OP_PUNCH;
  wire adv = step_advance_req & run_ff & ~ext_wait_ff;
  wire [7:0] pulse_now;
  wire locked = (is_tape & |(tape_busy_ff & unit_hot)) | (is_tw & tw_busy_ff) | (is_hp & hp_busy_ff);
  wire free = (is_tape & ~|(tape_busy_ff & unit_hot)) | (is_tw & ~tw_busy_ff) | (is_hp & ~hp_busy_ff);
  wire test_hit = pulse_now[1] & locked;
  wire [3:0] tape_arm = (adv & is_tape & pulse_now[5]) ? unit_hot : 4'h0;
  wire tw_arm = adv & is_tw & pulse_now[2];
  wire hp_arm = adv & is_hp & pulse_now[2];
  wire rw_wait = adv & is_rw & pulse_now[5];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_tape
      // One lockout circuit per tape unit.
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tape_busy_ff[gi] <= 1'b0;
        end else if (tape_arm[gi]) begin
          tape_busy_ff[gi] <= 1'b1;
        end else if (tape_done[gi]) begin
          tape_busy_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tw_busy_ff <= 1'b0;
      hp_busy_ff <= 1'b0;
    end else begin
      if (tw_arm) begin
        tw_busy_ff <= 1'b1;
      end else if (typewriter_done) begin
        tw_busy_ff <= 1'b0;
      end
      if (hp_arm) begin
        hp_busy_ff <= 1'b1;
      end else if (punch_done) begin
        hp_busy_ff <= 1'b0;
      end
    end
  end

  // Wait is set by a locked test or a transfer and cleared by the next advance request once the unit frees.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_wait_ff <= 1'b0;
    end else if (start_sel_ff) begin
      ext_wait_ff <= 1'b0;
    end else if ((step_advance_req & run_ff & ~ext_wait_ff & test_hit) | rw_wait) begin
      ext_wait_ff <= 1'b1;
    end else if (ext_wait_ff & free & step_advance_req) begin
      ext_wait_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Step pulse distributor
  // ----------------------------------------------------------------
  reg [2:0] last_pre;
  always @* begin
    case (opcode)
      6'o11, 6'o13, 6'o15, 6'o16, 6'o44, 6'o45, 6'o46, 6'o56: last_pre = 3'd0;
      6'o12, 6'o17, 6'o31, 6'o32, 6'o33, 6'o34, 6'o47, 6'o76, 6'o77: last_pre = 3'd1;
      6'o14, 6'o35, 6'o36, 6'o51, 6'o54: last_pre = 3'd2;
      6'o42, 6'o52, 6'o53, 6'o55, 6'o71, 6'o72, 6'o73: last_pre = 3'd3;
      default: last_pre = 3'd4;
    endcase
  end

  wire [7:0] gate_en;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gate
      if (gi < 5) begin : g_pre
        assign gate_en[gi] = (step_ff == gi) && (gi <= last_pre);
      end else if (gi == 5) begin : g_five
        assign gate_en[gi] = ~|{gate_en[7:6], gate_en[4:0]};
      end else begin : g_post
        assign gate_en[gi] = step_ff == gi;
      end
    end
  endgenerate
  assign pulse_now = gate_en;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_ff <= 3'd0;
      step_pulse <= 8'h00;
    end else begin
      step_pulse <= adv ? gate_en : 8'h00;
      if (special_load) begin
        step_ff <= special_step;
      end else if (adv) begin
        if (gate_en[5] && repeat_active) begin
          step_ff <= 3'd7;
        end else if (gate_en[5]) begin
          step_ff <= 3'd6;
        end else begin
          step_ff <= step_ff + 3'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Run control and outputs
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_ff <= 1'b0;
      start_sel_ff <= 1'b0;
    end else begin
      start_sel_ff <= ph_wr_ff && ph_addr_ff == `SPS_CTRL_OFS && hwdata[`SPS_CTRL_CLEAR_BIT];
      if (ph_wr_ff && ph_addr_ff == `SPS_CTRL_OFS && hwdata[`SPS_CTRL_STOP_BIT]) begin
        run_ff <= 1'b0;
      end else if (ph_wr_ff && ph_addr_ff == `SPS_CTRL_OFS && hwdata[`SPS_CTRL_START_BIT]) begin
        run_ff <= 1'b1;
      end else if (adv && (opcode == `SPS_OP_STOP) && gate_en[0]) begin
        run_ff <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tape_permit <= 4'hf;
      typewriter_permit <= 1'b1;
      punch_permit <= 1'b1;
      ext_wait <= 1'b0;
      arm_tape_busy <= 4'h0;
      tape_xfer_wait_req <= 1'b0;
      print_start <= 1'b0;
      punch_start <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      tape_permit <= ~(tape_busy_ff | tape_arm);
      typewriter_permit <= ~(tw_busy_ff | tw_arm);
      punch_permit <= ~(hp_busy_ff | hp_arm);
      ext_wait <= ext_wait_ff;
      arm_tape_busy <= tape_arm;
      tape_xfer_wait_req <= rw_wait;
      print_start <= tw_arm;
      punch_start <= hp_arm;
      if (ph_rd_ff || req & ~hwrite) begin
        case (haddr[7:0])
          `SPS_CTRL_OFS: hrdata <= {30'h0, 1'b0, run_ff};
          `SPS_STAT_OFS: hrdata <= {22'h0, step_ff, ext_wait_ff, hp_busy_ff, tw_busy_ff, tape_busy_ff};
          `SPS_PULSE_OFS: hrdata <= {24'h0, gate_en};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // sps_sequencer
